// ### src/scsc_serial_unit.sv
// Smart card serial unit: APB registers, card clock, frame engine
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

//
// Overview of operation
// - Only transmit-empty, receive-full and link-error requests exist; no transmit-end.
// - Transmit-empty request follows the done flag, gated by the transmit mask.
// - Receive-full request follows the full flag, gated by the receive mask.
// - Link-error request follows overrun, parity or error-signal, gated by receive mask.
// - A DMA transmit data write clears the transmit done flag.
// - A rejected character is resent automatically; done stays clear meanwhile.
// - Error-signal flag is only cleared by software, via the flag register.
// - A DMA read of received data clears the receive-full flag.
// - Receive errors set an error flag only, never the full flag.
// - Receiver counts 372 base clocks per bit, latches on the 186th.
// - A parity failure sets the parity flag and not the full flag.
// - A good parity check sets the full flag and raises its request.
// - After a good frame the data line stays released in the error slot.
// - An error signal after transmit sets its flag and leaves done clear.
// - No error signal: done is set and the empty request raised.
// - Clearing clock enable finishes the period, then holds the idle level.
// - After reset the clock pin floats until card mode is selected.
module scsc_serial_unit #(
  parameter int unsigned SCK_HALF = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic [4:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // DMA side
  input  wire logic        dma_tx_we,
  input  wire logic [7:0]  dma_tx_data,
  input  wire logic        dma_rx_re,
  output logic      [7:0]  rx_byte,
  // Requests
  output logic             tx_empty_irq,
  output logic             rx_full_irq,
  output logic             link_error_irq,
  // Card pins
  input  wire logic        card_io_in,
  output logic             card_io_out,
  output logic             card_io_oe,
  output logic             card_clk_out,
  output logic             card_clk_oe
);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus

  scsc_pkg::scsc_ctrl_s  ctrl_q;
  scsc_pkg::scsc_flag_s  flag_q;
  scsc_pkg::scsc_flag_s  flag_set;
  scsc_pkg::scsc_flag_s  flag_clr;
  scsc_pkg::scsc_state_e state_q;
  scsc_pkg::scsc_state_e state_d;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [7:0]  rx_data_q;
  logic [7:0]  tx_data_q;
  logic        tx_full_q;
  logic        clk_act_q;
  logic        clk_out_q;
  logic        oe_q;

  wire setup   = psel && !penable;
  wire access  = psel && penable;
  wire wr      = access && pwrite;
  wire hit     = paddr == scsc_pkg::CTRL_OFF || paddr == scsc_pkg::FLAG_OFF
              || paddr == scsc_pkg::TXD_OFF  || paddr == scsc_pkg::RXD_OFF
              || paddr == scsc_pkg::STAT_OFF;
  wire wr_ctrl = wr && paddr == scsc_pkg::CTRL_OFF;
  wire wr_flag = wr && paddr == scsc_pkg::FLAG_OFF;
  wire wr_txd  = wr && paddr == scsc_pkg::TXD_OFF;
  wire tx_load = wr_txd || dma_tx_we;
  wire [7:0] tx_in = dma_tx_we ? dma_tx_data : pwdata[7:0];
  wire [31:0] stat_word = {28'h0000000, oe_q, clk_out_q,
                           state_q != scsc_pkg::ST_IDLE, tx_full_q};

  function automatic logic [31:0] rd_mux(input logic [4:0] a);
    case (a)
      scsc_pkg::CTRL_OFF: rd_mux = {24'h000000, ctrl_q};
      scsc_pkg::FLAG_OFF: rd_mux = {27'h0000000, flag_q};
      scsc_pkg::TXD_OFF:  rd_mux = {24'h000000, tx_data_q};
      scsc_pkg::RXD_OFF:  rd_mux = {24'h000000, rx_data_q};
      scsc_pkg::STAT_OFF: rd_mux = stat_word;
      default:            rd_mux = 32'h00000000;
    endcase
  endfunction

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h00000000 : rd_mux(paddr);
      pslverr_q <= !hit;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access && pslverr_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= scsc_pkg::scsc_ctrl_s'(scsc_pkg::CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_q <= scsc_pkg::scsc_ctrl_s'(pwdata[7:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Card clock: toggles stop and start only at duty-preserving edges

  logic [7:0] sck_cnt_q;
  logic       sck_ph_q;
  wire half_end  = sck_cnt_q == 8'(SCK_HALF - 1);
  wire base_tick = half_end && !sck_ph_q;
  wire ph_next   = ~sck_ph_q;
  wire clk_start = half_end && !clk_act_q && ctrl_q.clock_out_on
                && ph_next != ctrl_q.clock_idle_level;
  wire clk_stop  = half_end && clk_act_q && !ctrl_q.clock_out_on
                && ph_next == ctrl_q.clock_idle_level;
  wire act_d     = clk_start ? 1'b1 : clk_stop ? 1'b0 : clk_act_q;
  wire ph_d      = half_end ? ph_next : sck_ph_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_cnt_q <= 8'h00;
      sck_ph_q  <= 1'b0;
      clk_act_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      sck_cnt_q <= half_end ? 8'h00 : sck_cnt_q + 8'h01;
      sck_ph_q  <= ph_d;
      clk_act_q <= act_d;
      clk_out_q <= act_d ? ph_d : ctrl_q.clock_idle_level;
    end
  end

  assign card_clk_out = clk_out_q;
  assign card_clk_oe  = ctrl_q.card_mode;

  //////////////////////////////////////////////////////////////////////////////
  // Data line synchroniser

  logic io_s1_q;
  logic io_s2_q;
  logic io_s3_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_s1_q <= 1'b1;
      io_s2_q <= 1'b1;
      io_s3_q <= 1'b1;
    end else begin
      io_s1_q <= card_io_in;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
    end
  end

  wire io_fall = io_s3_q && !io_s2_q;

  //////////////////////////////////////////////////////////////////////////////
  // Frame engine

  logic [8:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] rx_sh_q;
  logic       err_seen_q;

  wire samp     = base_tick && cnt_q == scsc_pkg::SAMPLE_TICK - 9'h001;
  wire wrap     = base_tick && cnt_q == scsc_pkg::BASE_PER_BIT - 9'h001;
  wire [9:0] tx_frame = {^tx_data_q ^ ctrl_q.parity_odd, tx_data_q, 1'b0};
  wire par_bad  = ^rx_sh_q ^ io_s2_q ^ ctrl_q.parity_odd;
  wire rx_start = state_q == scsc_pkg::ST_IDLE && ctrl_q.rx_enable_bit
               && io_fall;
  wire tx_start = state_q == scsc_pkg::ST_IDLE && ctrl_q.tx_enable_bit
               && !rx_start && tx_full_q;
  wire rx_last  = state_q == scsc_pkg::ST_RX && samp
               && bit_q == scsc_pkg::PARITY_BIT;
  wire tx_check = state_q == scsc_pkg::ST_TX && wrap
               && bit_q == scsc_pkg::ERR_BIT;
  wire tx_ok    = state_q == scsc_pkg::ST_TX && wrap && !err_seen_q
               && bit_q == scsc_pkg::ERR_END;
  wire tx_retry = state_q == scsc_pkg::ST_TX && wrap && err_seen_q
               && bit_q == scsc_pkg::RETRY_BIT;
  wire err_on   = state_q == scsc_pkg::ST_RX_ERR && samp
               && bit_q == scsc_pkg::ERR_BIT;
  wire err_off  = state_q == scsc_pkg::ST_RX_ERR && samp
               && bit_q == scsc_pkg::ERR_END;

  always_comb begin
    state_d = state_q;
    case (state_q)
      scsc_pkg::ST_IDLE: begin
        if (rx_start) begin
          state_d = scsc_pkg::ST_RX;
        end else if (tx_start) begin
          state_d = scsc_pkg::ST_TX;
        end
      end
      scsc_pkg::ST_TX: begin
        if (tx_ok || !ctrl_q.tx_enable_bit) begin
          state_d = scsc_pkg::ST_IDLE;
        end
      end
      scsc_pkg::ST_RX: begin
        if (!ctrl_q.rx_enable_bit) begin
          state_d = scsc_pkg::ST_IDLE;
        end else if (rx_last) begin
          state_d = par_bad ? scsc_pkg::ST_RX_ERR : scsc_pkg::ST_IDLE;
        end
      end
      scsc_pkg::ST_RX_ERR: begin
        if (err_off) begin
          state_d = scsc_pkg::ST_IDLE;
        end
      end
      default: state_d = scsc_pkg::ST_IDLE;
    endcase
  end

  // Open-drain drive: transmit zeros, or the receive error signal
  wire tx_drive = state_q == scsc_pkg::ST_TX && bit_q <= scsc_pkg::PARITY_BIT
               && !tx_frame[bit_q];
  wire oe_d = state_d == scsc_pkg::ST_TX ? tx_drive && !tx_retry
            : err_on ? 1'b1 : err_off ? 1'b0
            : state_q == scsc_pkg::ST_RX_ERR && oe_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= scsc_pkg::ST_IDLE;
      cnt_q   <= 9'h000;
      bit_q   <= 4'h0;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      oe_q    <= oe_d;
      if (rx_start || tx_start || tx_retry) begin
        cnt_q <= 9'h000;
        bit_q <= 4'h0;
      end else if (wrap) begin
        cnt_q <= 9'h000;
        bit_q <= bit_q + 4'h1;
      end else if (base_tick) begin
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sh_q    <= 8'h00;
      rx_data_q  <= 8'h00;
      tx_data_q  <= 8'h00;
      tx_full_q  <= 1'b0;
      err_seen_q <= 1'b0;
    end else begin
      if (state_q == scsc_pkg::ST_RX && samp && bit_q != 4'h0
          && bit_q < scsc_pkg::PARITY_BIT) begin
        rx_sh_q <= {io_s2_q, rx_sh_q[7:1]};
      end
      if (rx_last && !par_bad && !flag_q.rx_full_flag) begin
        rx_data_q <= rx_sh_q;
      end
      if (tx_load) begin
        tx_data_q <= tx_in;
      end
      tx_full_q <= tx_load || (tx_full_q && !tx_start);
      if (tx_start || tx_retry) begin
        err_seen_q <= 1'b0;
      end else if (tx_check) begin
        err_seen_q <= !io_s2_q;
      end
    end
  end

  assign card_io_oe  = oe_q;
  assign card_io_out = 1'b0;
  assign rx_byte     = rx_data_q;

  //////////////////////////////////////////////////////////////////////////////
  // Status flags: a set in the same cycle as a clear wins

  assign flag_set.rx_full_flag      = rx_last && !par_bad
                                   && !flag_q.rx_full_flag;
  assign flag_set.parity_error_flag = rx_last && par_bad;
  assign flag_set.overrun_flag      = rx_last && !par_bad
                                   && flag_q.rx_full_flag;
  assign flag_set.tx_done_flag      = tx_ok;
  assign flag_set.error_signal_flag = tx_check && !io_s2_q;
  assign flag_clr = (wr_flag ? ~scsc_pkg::scsc_flag_s'(pwdata[4:0])
                             : scsc_pkg::scsc_flag_s'(5'h00))
                  | {1'b0, tx_load, 2'b00, dma_rx_re};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= scsc_pkg::scsc_flag_s'(scsc_pkg::FLAG_RST);
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  // Three request lines only
  assign tx_empty_irq   = flag_q.tx_done_flag && ctrl_q.tx_irq_mask;
  assign rx_full_irq    = flag_q.rx_full_flag && ctrl_q.rx_irq_mask;
  assign link_error_irq = ctrl_q.rx_irq_mask && (flag_q.overrun_flag
                       || flag_q.parity_error_flag
                       || flag_q.error_signal_flag);

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence rx_begin_s;
    $rose(state_q == scsc_pkg::ST_RX);
  endsequence

  sequence parity_fail_s;
    $rose(flag_q.parity_error_flag);
  endsequence

  rx_sync_start_a: assert property (
    rx_begin_s |-> cnt_q == 9'h000 && bit_q == 4'h0 && $past(io_s3_q)
  ) else $error("receive did not start on a falling edge");

  rx_full_src_a: assert property (
    $rose(flag_q.rx_full_flag) |-> $past(state_q) == scsc_pkg::ST_RX
      && $past(bit_q) == scsc_pkg::PARITY_BIT
      && $past(cnt_q) == scsc_pkg::SAMPLE_TICK - 9'h001
  ) else $error("full flag set outside the parity latch point");

  parity_no_full_a: assert property (
    parity_fail_s |-> !$rose(flag_q.rx_full_flag)
      && state_q == scsc_pkg::ST_RX_ERR
  ) else $error("parity failure set full or missed error slot");

  good_frame_hiz_a: assert property (
    state_q == scsc_pkg::ST_IDLE || state_q == scsc_pkg::ST_RX
      |-> !card_io_oe
  ) else $error("line driven during or after a good receive frame");

  err_drive_a: assert property (
    $rose(card_io_oe) && state_q == scsc_pkg::ST_RX_ERR
      |-> bit_q == scsc_pkg::ERR_BIT && cnt_q == scsc_pkg::SAMPLE_TICK
  ) else $error("error signal not started mid error slot");

  errsig_no_done_a: assert property (
    $rose(flag_q.error_signal_flag) |-> !flag_q.tx_done_flag
      ##1 !$rose(flag_q.tx_done_flag)
  ) else $error("done flag set for a rejected frame");

  dma_tx_clear_a: assert property (
    dma_tx_we && state_q == scsc_pkg::ST_IDLE |=> !flag_q.tx_done_flag
  ) else $error("transmit write did not clear done flag");

  dma_rx_clear_a: assert property (
    dma_rx_re && !rx_last |=> !flag_q.rx_full_flag
  ) else $error("receive read did not clear full flag");

  eri_gate_a: assert property (
    link_error_irq |-> ctrl_q.rx_irq_mask && (flag_q.overrun_flag
      || flag_q.parity_error_flag || flag_q.error_signal_flag)
  ) else $error("link error request without mask or flag");

  clk_hold_a: assert property (
    !clk_act_q && !$past(clk_act_q) |-> card_clk_out
      == $past(ctrl_q.clock_idle_level)
  ) else $error("stopped clock not at idle level");

endmodule

`default_nettype wire

// ### src/scsc_pkg.sv
// Package: register map, field layouts, timing counts and states
package scsc_pkg;

  // Register byte offsets
  localparam logic [4:0] CTRL_OFF  = 5'h00;
  localparam logic [4:0] FLAG_OFF  = 5'h04;
  localparam logic [4:0] TXD_OFF   = 5'h08;
  localparam logic [4:0] RXD_OFF   = 5'h0c;
  localparam logic [4:0] STAT_OFF  = 5'h10;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [4:0] FLAG_RST  = 5'h08;

  // Base clock cycles per bit and receive latch point
  localparam logic [8:0] BASE_PER_BIT = 9'h174;
  localparam logic [8:0] SAMPLE_TICK  = 9'h0ba;

  // Bit slots within a frame, counted from the start bit
  localparam logic [3:0] PARITY_BIT = 4'h9;
  localparam logic [3:0] ERR_BIT    = 4'ha;
  localparam logic [3:0] ERR_END    = 4'hb;
  localparam logic [3:0] RETRY_BIT  = 4'hc;

  // Control register layout, bit 0 last
  typedef struct packed {
    logic card_mode;
    logic parity_odd;
    logic clock_idle_level;
    logic clock_out_on;
    logic rx_irq_mask;
    logic tx_irq_mask;
    logic rx_enable_bit;
    logic tx_enable_bit;
  } scsc_ctrl_s;

  // Flag register layout, bit 0 last
  typedef struct packed {
    logic error_signal_flag;
    logic tx_done_flag;
    logic overrun_flag;
    logic parity_error_flag;
    logic rx_full_flag;
  } scsc_flag_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TX,
    ST_RX,
    ST_RX_ERR
  } scsc_state_e;

endpackage

// ### dv/scsc_card_model.sv
// Behavioural smart card on the far side of the data line
`timescale 1ns/1ps
`default_nettype none

module scsc_card_model (
  // Card pins
  input  wire logic card_clk,
  input  wire logic io_line,
  // Open-drain pull on the data line
  output logic      drive_low
);
  int         nack_cnt = 0;
  int         frames   = 0;
  bit         sending  = 1'b0;
  bit         err_seen = 1'b0;
  logic [7:0] got      = 8'h00;
  logic [8:0] sh;

  initial drive_low = 1'b0;

  task automatic etu(input int n);
    repeat (n) @(posedge card_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Take a frame from the unit; answer bad parity or a forced reject low
  always begin
    @(negedge io_line iff !sending);
    etu(186);
    for (int i = 0; i < 9; i++) begin
      etu(372);
      sh[i] = io_line;
    end
    got = sh[7:0];
    frames++;
    if ((^sh) || nack_cnt > 0) begin
      if (nack_cnt > 0) nack_cnt--;
      etu(372);
      drive_low = 1'b1;
      etu(372);
      drive_low = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Send one frame, even parity unless spoilt; watch the error slot
  task automatic send(input logic [7:0] d, input bit bad);
    logic [9:0] f;
    f = {(^d) ^ bad, d, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 10; i++) begin
      drive_low = !f[i];
      etu(372);
    end
    drive_low = 1'b0;
    etu(279);
    err_seen = !io_line;
    etu(465);
    sending = 1'b0;
  endtask

endmodule

`default_nettype wire

// ### dv/test_scsc_serial_unit.sv
// Self-checking bench for the smart card serial unit
`timescale 1ns/1ps
`default_nettype none

module test_scsc_serial_unit;
  logic        clk         = 1'b0;
  logic        rst_b       = 1'b0;
  logic [4:0]  paddr       = 5'h00;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [31:0] pwdata      = 32'h0;
  logic        dma_tx_we   = 1'b0;
  logic [7:0]  dma_tx_data = 8'h00;
  logic        dma_rx_re   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  rx_byte;
  logic        tx_empty_irq;
  logic        rx_full_irq;
  logic        link_error_irq;
  logic        card_io_out;
  logic        card_io_oe;
  logic        card_clk_out;
  logic        card_clk_oe;
  logic        card_low;
  wire logic   io_line = !(card_io_oe && !card_io_out) && !card_low;
  int          fails     = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  logic [31:0] lfsr      = 32'h6efc7cfd;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  d;
  bit          oe_seen;

  always #5 clk = ~clk;

  scsc_serial_unit #(.SCK_HALF(1)) i_scsc_serial_unit (
    .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_tx_we(dma_tx_we), .dma_tx_data(dma_tx_data),
    .dma_rx_re(dma_rx_re), .rx_byte(rx_byte),
    .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
    .link_error_irq(link_error_irq), .card_io_in(io_line),
    .card_io_out(card_io_out), .card_io_oe(card_io_oe),
    .card_clk_out(card_clk_out), .card_clk_oe(card_clk_oe)
  );

  scsc_card_model i_scsc_card_model (
    .card_clk(card_clk_out), .io_line(io_line), .drive_low(card_low)
  );

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Flag word from its five fields
  function automatic logic [31:0] fl(input logic f, p, o, t, e);
    return {27'h0, e, t, o, p, f};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // The wait ends once pready is high; only the cycle ceiling of the bench bounds it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_on(input bit lnk);
    int n;
    n = 0;
    while (n < 20000 && (lnk ? link_error_irq : tx_empty_irq) !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20000) chk(32'h0, 32'h1);
  endtask

  task automatic dma_tx(input logic [7:0] b);
    @(posedge clk);
    dma_tx_we   <= 1'b1;
    dma_tx_data <= b;
    @(posedge clk);
    dma_tx_we <= 1'b0;
    @(negedge clk);
    chk(tx_empty_irq, 0);
  endtask

  task automatic ctrl(input logic [7:0] v);
    apb(1'b1, scsc_pkg::CTRL_OFF, {24'h0, v});
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (card_io_oe === 1'b1) oe_seen = 1'b1;
    if (cyc == 90000) begin
      fails++;
      end_of_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    chk(card_clk_oe, 0);
    chk({tx_empty_irq, rx_full_irq, link_error_irq}, 0);
    rdchk(scsc_pkg::CTRL_OFF, {24'h0, scsc_pkg::CTRL_RST});
    rdchk(scsc_pkg::FLAG_OFF, fl(0, 0, 0, 1, 0));
    apb(1'b0, 5'h14, 32'h0);
    chk(err, 1);
    chk(rd, 0);
    // Transmit mode, transmit mask tried both ways; DMA lines idle beforehand
    ctrl(8'h99);
    chk(tx_empty_irq, 0);
    chk(card_clk_oe, 1);
    ctrl(8'h9d);
    chk(tx_empty_irq, 1);
    d = lfsr[7:0];
    lfsr = next_rand(lfsr);
    dma_tx(d);
    wait_on(1'b0);
    chk(i_scsc_card_model.got, d);
    chk(link_error_irq, 0);
    rdchk(scsc_pkg::FLAG_OFF, fl(0, 0, 0, 1, 0));
    // Card rejects once; the same byte goes again
    i_scsc_card_model.nack_cnt = 1;
    dma_tx(8'h00);
    wait_on(1'b1);
    chk(tx_empty_irq, 0);
    rdchk(scsc_pkg::FLAG_OFF, fl(0, 0, 0, 0, 1));
    apb(1'b1, scsc_pkg::FLAG_OFF, 32'h0f);
    @(negedge clk);
    chk(link_error_irq, 0);
    wait_on(1'b0);
    chk(i_scsc_card_model.frames, 3);
    chk(i_scsc_card_model.got, 0);
    // Receive mode, entered only after transmit is done
    ctrl(8'h98);
    ctrl(8'h9a);
    for (int k = 0; k < 2; k++) begin
      oe_seen = 1'b0;
      i_scsc_card_model.send(k == 0 ? d : lfsr[7:0], 1'b0);
      lfsr = next_rand(lfsr);
      chk(rx_full_irq, 1);
      chk(rx_byte, d);
      chk(oe_seen, 0);
      chk(link_error_irq, k);
      rdchk(scsc_pkg::FLAG_OFF, fl(1, 0, k, 1, 0));
    end
    ctrl(8'h92);
    chk({rx_full_irq, link_error_irq}, 0);
    ctrl(8'h9a);
    chk(rx_full_irq, 1);
    @(posedge clk);
    dma_rx_re <= 1'b1;
    @(posedge clk);
    dma_rx_re <= 1'b0;
    @(negedge clk);
    chk(rx_full_irq, 0);
    apb(1'b1, scsc_pkg::FLAG_OFF, 32'h1b);
    rdchk(scsc_pkg::FLAG_OFF, fl(0, 0, 0, 1, 0));
    // Bad parity: error flag, error signal, no full flag
    i_scsc_card_model.send(8'hff, 1'b1);
    chk(link_error_irq, 1);
    chk(rx_full_irq, 0);
    chk(i_scsc_card_model.err_seen, 1);
    rdchk(scsc_pkg::FLAG_OFF, fl(0, 1, 0, 1, 0));
    ctrl(8'h92);
    chk(link_error_irq, 0);
    apb(1'b1, scsc_pkg::FLAG_OFF, 32'h1d);
    rdchk(scsc_pkg::FLAG_OFF, fl(0, 0, 0, 1, 0));
    // Odd parity: a frame with odd ones is good
    ctrl(8'hda);
    d = lfsr[7:0];
    lfsr = next_rand(lfsr);
    i_scsc_card_model.send(d, 1'b1);
    chk(rx_full_irq, 1);
    chk(rx_byte, d);
    chk(i_scsc_card_model.err_seen, 0);
    // Clock stops at the idle level, then restarts
    ctrl(8'ha0);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      chk(card_clk_out, 1);
    end
    ctrl(8'hb0);
    // Restart leaves the high idle level with a full low half period
    for (int k = 0; k < 8 && card_clk_out === 1'b1; k++) begin
      @(negedge clk);
    end
    chk(card_clk_out, 0);
    @(negedge clk);
    chk(card_clk_out, 1);
    end_of_test();
  end

endmodule

`default_nettype wire
